// [uci_host_model.sv]
/*
 bus master model for uci_top: frames writes and reads on the transaction layer.
 assumes the testbench calls its tasks; every line changes at the falling clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module uci_host_model (
  // clock
  input wire logic sys_clk,
  // transaction layer
  output logic txn_begin,
  output logic [7:0] txn_cmd,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic txn_end,
  output logic txn_pec_ok,
  output logic rd_req
);
  import uci_pkg::*;

  initial begin
    txn_begin = 1'b0;
    txn_cmd = 8'h00;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    txn_end = 1'b0;
    txn_pec_ok = 1'b0;
    rd_req = 1'b0;
  end

  // code, then bytes; released lines flip so a stale value never looks valid
  task automatic send(input logic [7:0] cmd, input logic [7:0] bytes[$], input logic stop,
                      input logic pec);
    @(negedge sys_clk);
    txn_begin = 1'b1;
    txn_cmd = cmd;
    foreach (bytes[i]) begin
      @(negedge sys_clk);
      txn_begin = 1'b0;
      txn_cmd = ~txn_cmd;
      wr_valid = 1'b1;
      wr_data = bytes[i];
    end
    @(negedge sys_clk);
    txn_begin = 1'b0;
    wr_valid = 1'b0;
    wr_data = ~wr_data;
    txn_cmd = ~txn_cmd;
    txn_end = stop;
    txn_pec_ok = stop & pec;
    @(negedge sys_clk);
    txn_end = 1'b0;
    txn_pec_ok = 1'b0;
  endtask

  // password write: count four, three fixed characters and the given last one, then stop with pec as given
  task automatic unlock(input logic [7:0] last, input logic pec);
    send(CMD_PASSWORD, '{PW_COUNT, PW_CHAR_0, PW_CHAR_1, PW_CHAR_2, last}, 1'b1, pec);
  endtask

  // repeated start read: back-to-back requests, one per byte wanted
  task automatic rd(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      rd_req = 1'b1;
    end
    @(negedge sys_clk);
    rd_req = 1'b0;
  endtask
endmodule // uci_host_model
`default_nettype wire

// [uci_info_mem.sv]
/*
 byte memory holding compatibility code, revision and capability per processor.
 assumes one writer (firmware load port) and one reader; read data registered.
*/
`timescale 1ns/1ns
`default_nettype none
module uci_info_mem #(
  parameter int AW = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // load side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read side
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_q
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_q <= 8'h0000;
    end else if (rd_en) begin
      rd_q <= mem[rd_addr];
    end
  end
endmodule // uci_info_mem
`default_nettype wire

// [uci_pkg.sv]
/*
 upgrade command interface package: command codes, characters, counts, timing.
 assumes a 250 MHz system clock; used by uci_top, uci_host_model and uci_top_tb.
*/
package uci_pkg;
  localparam logic [7:0] CMD_PASSWORD = 8'h00_E0;
  localparam logic [7:0] CMD_TARGETS = 8'h00_E1;
  localparam logic [7:0] CMD_COMPAT = 8'h00_E2;
  localparam logic [7:0] CMD_REVISION = 8'h00_E3;
  localparam logic [7:0] CMD_CAPABILITY = 8'h00_E4;
  localparam logic [7:0] PW_COUNT = 8'h0004;
  localparam logic [7:0] PW_CHAR_0 = 8'h0055;
  localparam logic [7:0] PW_CHAR_1 = 8'h0050;
  localparam logic [7:0] PW_CHAR_2 = 8'h0047;
  localparam logic [7:0] PW_CHAR_3 = 8'h0044;
  localparam logic [2:0] PW_LEN = 3'h5;
  localparam logic [7:0] CHAR_PRIMARY = 8'h0070;
  localparam logic [7:0] CHAR_SECONDARY = 8'h0073;
  localparam logic [7:0] CHAR_INTERFACE = 8'h0069;
  localparam logic [7:0] NO_DATA = 8'h00FF;
  localparam logic [4:0] COUNT_TARGETS = 5'h03;
  localparam logic [4:0] COUNT_COMPAT = 5'h10;
  localparam logic [4:0] COUNT_REVISION = 5'h07;
  localparam logic [4:0] COUNT_CAPABILITY = 5'h07;
  localparam logic [1:0] TGT_PRIMARY = 2'h0;
  localparam logic [1:0] TGT_SECONDARY = 2'h1;
  localparam logic [1:0] TGT_INTERFACE = 2'h2;
  localparam logic [1:0] TGT_NONE = 2'h3;
  localparam logic [1:0] SEC_COMPAT = 2'h0;
  localparam logic [1:0] SEC_REVISION = 2'h1;
  localparam logic [1:0] SEC_CAPABILITY = 2'h2;
  localparam int INFO_AW = 8;
  localparam longint CLK_HZ = 250_000_000;
  localparam longint LAMP_PHASE_MS = 250;
  localparam longint ADDR_SETTLE_S = 15;
  localparam longint LAMP_PHASE_CYCLES = LAMP_PHASE_MS * CLK_HZ / 1000;
  localparam longint ADDR_SETTLE_CYCLES = ADDR_SETTLE_S * CLK_HZ;
  localparam logic [2:0] DEFAULT_ADDR_LOW = 3'h0;
  localparam int FAN_LIMIT_DIV = 5;
  typedef enum {UCI_IDLE, UCI_BOOT_GOOD, UCI_UPGRADING, UCI_FAULT} uci_boot_type;
endpackage

// [uci_top.sv]
/*
 upgrade command interface: state-change alert, hot-plug address, upgrade front end
 and fault lamp coding. assumes a pmbus transaction layer that frames commands,
 checks pec and turns read requests into bytes; all inputs synchronous to sys_clk.
*/
// Contract
// - raise a state-change alert at first power-up after reset
// - power-up attention stays set until the master reads status
// - any change in standard or vendor status bits raises the alert
// - answer on address with low three bits zero until settle time ends
// - remote off extinguishes the output good lamp
// - warn without shutdown when fan speeds differ by over twenty percent
// - information-only alarms are reported and never cause a shutdown
// - application runs after reset only when the upgrade validated; here reset itself sets app_run high with no check
// - fault lamp: off idle, wink boot good, fast blink upgrading, on failed
// - wink is a quarter second lit, three quarters dark
// - fast blink is a quarter second lit, a quarter dark
// - boot loader switches the main output off before reprogramming
// - unlock is command e0, count four, chars upgd, valid pec
// - read of e1 returns p, s and i as ascii characters
// - selector byte is an ascii character p, s or i naming the target
// - read of e2 returns sixteen compatibility characters of the target
// - e3 returns count seven then revision and build date bytes
// - e4 reports the reprogramming capability of the selected target
// - capability holds max bytes, erase ms, write us and application crc
`timescale 1ns/1ns
`default_nettype none
module uci_top #(
  parameter logic [31:0] PHASE_CYCLES = 32'(uci_pkg::LAMP_PHASE_CYCLES),
  parameter logic [31:0] SETTLE_CYCLES = 32'(uci_pkg::ADDR_SETTLE_CYCLES),
  parameter int STATUS_W = 16,
  parameter int FAN_W = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // transaction layer
  input wire logic txn_begin,
  input wire logic [7:0] txn_cmd,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  input wire logic txn_end,
  input wire logic txn_pec_ok,
  input wire logic rd_req,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic cmd_ignored,
  output logic unlocked,
  // status and alert
  input wire logic [STATUS_W-1:0] std_status,
  input wire logic [STATUS_W-1:0] mfr_status,
  input wire logic status_read,
  input wire logic clear_faults,
  output logic alert,
  // addressing
  input wire logic [6:0] backplane_addr,
  output logic [6:0] bus_address,
  // info memory load
  input wire logic info_wr_en,
  input wire logic [uci_pkg::INFO_AW-1:0] info_wr_addr,
  input wire logic [7:0] info_wr_data,
  // monitoring
  input wire logic [FAN_W-1:0] fan_speed_a,
  input wire logic [FAN_W-1:0] fan_speed_b,
  input wire logic [8:0] info_alarms,
  output logic fan_warning,
  output logic info_warning,
  // boot loader events
  input wire logic boot_enter,
  input wire logic boot_erase,
  input wire logic boot_done_ok,
  input wire logic boot_done_fail,
  input wire logic boot_exit,
  output logic app_run,
  // output and lamps
  input wire logic output_request,
  input wire logic remote_off,
  input wire logic module_present_sense,
  output logic main_output_en,
  output logic output_good_lamp,
  output logic fault_lamp
);
  import uci_pkg::*;

  function automatic logic [1:0] tgt_code(input logic [7:0] ch);
    case (ch)
      CHAR_PRIMARY: tgt_code = TGT_PRIMARY;
      CHAR_SECONDARY: tgt_code = TGT_SECONDARY;
      CHAR_INTERFACE: tgt_code = TGT_INTERFACE;
      default: tgt_code = TGT_NONE;
    endcase
  endfunction

  function automatic logic fans_differ(input logic [FAN_W-1:0] a, input logic [FAN_W-1:0] b);
    logic [FAN_W-1:0] big;
    logic [FAN_W-1:0] diff;
    big = (a > b) ? a : b;
    diff = (a > b) ? (a - b) : (b - a);
    fans_differ = ((FAN_W+3)'(diff) * (FAN_W+3)'(FAN_LIMIT_DIV)) > (FAN_W+3)'(big);
  endfunction

  function automatic logic [7:0] pw_expect(input logic [2:0] pos);
    case (pos)
      3'h0: pw_expect = PW_COUNT;
      3'h1: pw_expect = PW_CHAR_0;
      3'h2: pw_expect = PW_CHAR_1;
      3'h3: pw_expect = PW_CHAR_2;
      3'h4: pw_expect = PW_CHAR_3;
      default: pw_expect = NO_DATA;
    endcase
  endfunction

  logic [7:0] cur_cmd;
  logic [2:0] wr_cnt;
  logic pw_match;
  logic [1:0] target;
  logic [4:0] byte_idx;
  logic [4:0] rd_count;
  logic [1:0] rd_sec;
  logic rd_allowed;
  logic rd_pend;
  logic [4:0] pend_idx;
  logic [7:0] mem_q;
  logic pu_pending;
  logic chg_pending;
  logic status_changed;
  logic [STATUS_W-1:0] prev_std;
  logic [STATUS_W-1:0] prev_mfr;
  logic [31:0] settle_cnt;
  logic settled;
  logic [31:0] phase_cnt;
  logic [1:0] phase;
  uci_boot_type boot_state;
  logic in_boot;
  logic next_fault_lamp;

  // command framing and unlock
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cur_cmd <= 8'h0000;
      wr_cnt <= 3'h0;
      pw_match <= 1'b0;
      target <= TGT_NONE;
      unlocked <= 1'b0;
    end else if (txn_begin) begin
      cur_cmd <= txn_cmd;
      wr_cnt <= 3'h0;
      pw_match <= 1'b1;
      target <= TGT_NONE;
    end else begin
      if (wr_valid) begin
        if (wr_cnt != 3'h7) begin
          wr_cnt <= wr_cnt + 3'h1;
        end
        if (wr_data != pw_expect(wr_cnt)) begin
          pw_match <= 1'b0;
        end
        if (wr_cnt == 3'h0) begin
          target <= tgt_code(wr_data);
        end
      end
      if (txn_end && cur_cmd == CMD_PASSWORD && pw_match && wr_cnt == PW_LEN && txn_pec_ok) begin
        unlocked <= 1'b1;
      end
    end
  end

  // read decode
  always_comb begin
    rd_count = 5'h00;
    rd_sec = SEC_COMPAT;
    rd_allowed = 1'b0;
    case (cur_cmd)
      CMD_TARGETS: begin
        rd_count = COUNT_TARGETS;
        rd_allowed = unlocked;
      end
      CMD_COMPAT: begin
        rd_count = COUNT_COMPAT;
        rd_allowed = unlocked && target != TGT_NONE;
      end
      CMD_REVISION: begin
        rd_count = COUNT_REVISION;
        rd_sec = SEC_REVISION;
        rd_allowed = unlocked && target != TGT_NONE;
      end
      CMD_CAPABILITY: begin
        rd_count = COUNT_CAPABILITY;
        rd_sec = SEC_CAPABILITY;
        rd_allowed = unlocked && target != TGT_NONE;
      end
      default: begin
        rd_allowed = 1'b0;
      end
    endcase
  end

  uci_info_mem #(.AW(INFO_AW)) u_info (
    .sys_clk(sys_clk),
    .reset(reset),
    .wr_en(info_wr_en),
    .wr_addr(info_wr_addr),
    .wr_data(info_wr_data),
    .rd_en(rd_req),
    .rd_addr({target, rd_sec, 4'(byte_idx - 5'h01)}),
    .rd_q(mem_q)
  );

  // read answer: count byte first, then data bytes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      byte_idx <= 5'h00;
      rd_pend <= 1'b0;
      pend_idx <= 5'h00;
      rd_valid <= 1'b0;
      rd_data <= 8'h0000;
      cmd_ignored <= 1'b0;
    end else begin
      rd_pend <= rd_req && rd_allowed;
      cmd_ignored <= rd_req && !rd_allowed;
      rd_valid <= rd_pend;
      if (txn_begin) begin
        byte_idx <= 5'h00;
      end else if (rd_req && rd_allowed && byte_idx != 5'h1F) begin
        byte_idx <= byte_idx + 5'h01;
      end
      if (rd_req) begin
        pend_idx <= byte_idx;
      end
      if (rd_pend) begin
        if (pend_idx == 5'h00) begin
          rd_data <= {3'h0, rd_count};
        end else if (pend_idx > rd_count) begin
          rd_data <= NO_DATA;
        end else if (cur_cmd == CMD_TARGETS) begin
          case (pend_idx)
            5'h01: rd_data <= CHAR_PRIMARY;
            5'h02: rd_data <= CHAR_SECONDARY;
            default: rd_data <= CHAR_INTERFACE;
          endcase
        end else begin
          rd_data <= mem_q;
        end
      end
    end
  end

  // state-change alert
  assign status_changed = (std_status != prev_std) || (mfr_status != prev_mfr);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prev_std <= '0;
      prev_mfr <= '0;
      pu_pending <= 1'b1;
      chg_pending <= 1'b0;
      alert <= 1'b0;
    end else begin
      prev_std <= std_status;
      prev_mfr <= mfr_status;
      if (status_read) begin
        pu_pending <= 1'b0;
      end
      if (status_changed) begin
        chg_pending <= 1'b1;
      end else if (clear_faults) begin
        chg_pending <= 1'b0;
      end
      alert <= pu_pending || chg_pending;
    end
  end

  // hot-plug address settling
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      settle_cnt <= 32'h0000_0000;
      settled <= 1'b0;
      bus_address <= 7'h00;
    end else begin
      if (!settled) begin
        settle_cnt <= settle_cnt + 32'h0000_0001;
        settled <= settle_cnt >= SETTLE_CYCLES - 32'h0000_0001;
      end
      bus_address <= settled ? backplane_addr : {backplane_addr[6:3], DEFAULT_ADDR_LOW};
    end
  end

  // monitoring warnings, no shutdown path
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fan_warning <= 1'b0;
      info_warning <= 1'b0;
    end else begin
      fan_warning <= fans_differ(fan_speed_a, fan_speed_b);
      info_warning <= |info_alarms;
    end
  end

  // boot loader state
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      boot_state <= UCI_IDLE;
      app_run <= 1'b1;
    end else begin
      case (boot_state)
        UCI_IDLE: begin
          if (boot_enter) begin
            boot_state <= UCI_BOOT_GOOD;
            app_run <= 1'b0;
          end
        end
        UCI_BOOT_GOOD: begin
          if (boot_erase) begin
            boot_state <= UCI_UPGRADING;
          end else if (boot_exit) begin
            boot_state <= UCI_IDLE;
            app_run <= 1'b1;
          end
        end
        UCI_UPGRADING: begin
          if (boot_done_ok) begin
            boot_state <= UCI_BOOT_GOOD;
          end else if (boot_done_fail) begin
            boot_state <= UCI_FAULT;
          end
        end
        UCI_FAULT: begin
          if (boot_erase) begin
            boot_state <= UCI_UPGRADING;
          end
        end
        default: begin
          boot_state <= UCI_IDLE;
        end
      endcase
    end
  end

  assign in_boot = boot_state != UCI_IDLE;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      main_output_en <= 1'b0;
      output_good_lamp <= 1'b0;
    end else begin
      main_output_en <= output_request && !remote_off && !in_boot;
      output_good_lamp <= output_request && !remote_off && !in_boot &&
        module_present_sense;
    end
  end

  // quarter-second lamp phases
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phase_cnt <= 32'h0000_0000;
      phase <= 2'h0;
    end else if (phase_cnt >= PHASE_CYCLES - 32'h0000_0001) begin
      phase_cnt <= 32'h0000_0000;
      phase <= phase + 2'h1;
    end else begin
      phase_cnt <= phase_cnt + 32'h0000_0001;
    end
  end

  always_comb begin
    case (boot_state)
      UCI_BOOT_GOOD: next_fault_lamp = phase == 2'h0;
      UCI_UPGRADING: next_fault_lamp = !phase[0];
      UCI_FAULT: next_fault_lamp = 1'b1;
      default: next_fault_lamp = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fault_lamp <= 1'b0;
    end else begin
      fault_lamp <= next_fault_lamp;
    end
  end

  a_powerup_alert: assert property (@(posedge sys_clk) disable iff (reset)
    pu_pending |=> alert) else $error("power-up alert missing");
  a_pending_hold: assert property (@(posedge sys_clk) disable iff (reset)
    pu_pending && !status_read |=> pu_pending) else $error("power-up flag dropped early");
  a_change_alert: assert property (@(posedge sys_clk) disable iff (reset)
    status_changed |=> ##1 alert) else $error("status change not alerted");
  a_default_addr: assert property (@(posedge sys_clk) disable iff (reset)
    !settled |=> bus_address[2:0] == 3'h0) else $error("address not defaulted");
  a_remote_off_lamp: assert property (@(posedge sys_clk) disable iff (reset)
    remote_off |=> !output_good_lamp) else $error("good lamp lit while off");
  a_fan_warn: assert property (@(posedge sys_clk) disable iff (reset)
    fan_speed_a > 16'h0000 && fan_speed_b == 16'h0000 |=> fan_warning)
    else $error("fan mismatch not warned");
  a_exit_gate: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(app_run) |-> $past(boot_state) == UCI_BOOT_GOOD)
    else $error("application run without validation");
  a_fault_lamp_on: assert property (@(posedge sys_clk) disable iff (reset)
    boot_state == UCI_FAULT [*2] |-> fault_lamp) else $error("fault lamp not steady");
  a_boot_output_off: assert property (@(posedge sys_clk) disable iff (reset)
    in_boot |=> !main_output_en) else $error("output on during boot");
  a_locked_ignore: assert property (@(posedge sys_clk) disable iff (reset)
    rd_req && !unlocked |=> cmd_ignored ##1 !rd_valid) else $error("locked read answered");
  a_count_first: assert property (@(posedge sys_clk) disable iff (reset)
    rd_req && rd_allowed && byte_idx == 5'h00 && cur_cmd == CMD_REVISION
    |=> ##1 rd_valid && rd_data == 8'h0007) else $error("revision count wrong");
  a_target_p: assert property (@(posedge sys_clk) disable iff (reset)
    rd_req && rd_allowed && cur_cmd == CMD_TARGETS && byte_idx == 5'h01
    |=> ##1 rd_data == 8'h0070) else $error("target list wrong");
  c_unlock: cover property (@(posedge sys_clk) $rose(unlocked));
  c_upgrade_ok: cover property (@(posedge sys_clk)
    boot_state == UCI_UPGRADING ##1 boot_state == UCI_BOOT_GOOD);
  c_compat_read: cover property (@(posedge sys_clk) rd_valid && cur_cmd == CMD_COMPAT);
  c_settled: cover property (@(posedge sys_clk) $rose(settled));
endmodule // uci_top
`default_nettype wire

// [uci_top_tb.sv]
/*
 self-checking testbench for uci_top, bus master model on the transaction side.
 assumes a 4 ns clock and shortened lamp phase and address settle counts.
*/
`timescale 1ns/1ns
`default_nettype none
module uci_top_tb;
  import uci_pkg::*;
  localparam int PHASE = 4;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic txn_begin, wr_valid, txn_end, txn_pec_ok, rd_req, rd_valid, cmd_ignored, unlocked;
  logic [7:0] txn_cmd, wr_data, rd_data;
  logic alert, fan_warning, info_warning, app_run, main_output_en, output_good_lamp, fault_lamp;
  logic [15:0] std_status = 16'h0000, mfr_status = 16'h0000;
  logic [15:0] fan_a = 16'h0000, fan_b = 16'h0000;
  logic status_read = 1'b0, clear_faults = 1'b0, info_wr_en = 1'b0;
  logic output_request = 1'b1, remote_off = 1'b0, present = 1'b1;
  logic [6:0] bp = 7'h00, bus_address;
  logic [7:0] info_wr_addr = 8'h00, info_wr_data = 8'h00;
  logic [8:0] alarms = 9'h000;
  logic [4:0] boot_ev = 5'h00;
  logic [7:0] img[256];
  logic [7:0] none[$];
  logic [8:0] exp_q[$];
  logic [7:0] sel_char[3] = '{CHAR_PRIMARY, CHAR_SECONDARY, CHAR_INTERFACE};
  int err_count = 0, total_checks = 0, cycles = 0;

  always #2 sys_clk = ~sys_clk;

  uci_host_model host (.sys_clk(sys_clk), .txn_begin(txn_begin), .txn_cmd(txn_cmd),
    .wr_valid(wr_valid), .wr_data(wr_data), .txn_end(txn_end), .txn_pec_ok(txn_pec_ok),
    .rd_req(rd_req));

  uci_top #(.PHASE_CYCLES(32'h0000_0004), .SETTLE_CYCLES(32'h0000_0014)) dut (
    .sys_clk(sys_clk), .reset(reset), .txn_begin(txn_begin), .txn_cmd(txn_cmd),
    .wr_valid(wr_valid), .wr_data(wr_data), .txn_end(txn_end), .txn_pec_ok(txn_pec_ok),
    .rd_req(rd_req), .rd_valid(rd_valid), .rd_data(rd_data), .cmd_ignored(cmd_ignored),
    .unlocked(unlocked), .std_status(std_status), .mfr_status(mfr_status),
    .status_read(status_read), .clear_faults(clear_faults), .alert(alert),
    .backplane_addr(bp), .bus_address(bus_address), .info_wr_en(info_wr_en),
    .info_wr_addr(info_wr_addr), .info_wr_data(info_wr_data), .fan_speed_a(fan_a),
    .fan_speed_b(fan_b), .info_alarms(alarms), .fan_warning(fan_warning),
    .info_warning(info_warning), .boot_enter(boot_ev[0]), .boot_erase(boot_ev[1]),
    .boot_done_ok(boot_ev[2]), .boot_done_fail(boot_ev[3]), .boot_exit(boot_ev[4]),
    .app_run(app_run), .output_request(output_request), .remote_off(remote_off),
    .module_present_sense(present), .main_output_en(main_output_en),
    .output_good_lamp(output_good_lamp), .fault_lamp(fault_lamp));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // one-cycle status read (clr low) or clear faults (clr high)
  task automatic ack(input logic clr);
    @(negedge sys_clk);
    status_read = ~clr;
    clear_faults = clr;
    @(negedge sys_clk);
    status_read = 1'b0;
    clear_faults = 1'b0;
  endtask

  // note the expected answers, then select and read
  task automatic do_read(input logic [7:0] cmd, input logic [7:0] sel[$], input logic [8:0] e[$]);
    foreach (e[i]) exp_q.push_back(e[i]);
    host.send(cmd, sel, 1'b0, 1'b0);
    host.rd(e.size());
  endtask

  // count, data from the loaded image, then the filler past the count
  task automatic info_read(input logic [7:0] cmd, input int t, input int sec, input int cnt);
    logic [8:0] e[$];
    e.push_back(9'(cnt));
    for (int b = 0; b < cnt; b++) e.push_back({1'b0, img[{t[1:0], sec[1:0], b[3:0]}]});
    e.push_back(9'h0FF);
    do_read(cmd, '{sel_char[t]}, e);
  endtask

  // lit cycles of the fault lamp over one slow-wink period
  task automatic lamp(input int lit);
    int n;
    n = 0;
    wait_cyc(8);
    repeat (4 * PHASE) begin
      @(negedge sys_clk);
      n += (fault_lamp === 1'b1);
    end
    check(32'(n), 32'(lit));
  endtask

  task automatic boot(input int i);
    @(negedge sys_clk);
    boot_ev[i] = 1'b1;
    @(negedge sys_clk);
    boot_ev = 5'h00;
  endtask

  // read answers: oldest note against each data byte or refusal
  always @(negedge sys_clk) begin
    if (rd_valid === 1'b1 || cmd_ignored === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(32'h0000_0001, 32'h0000_0000);
      end else begin
        check({23'h0, cmd_ignored, cmd_ignored ? 8'h00 : rd_data},
          32'(exp_q.pop_front()));
      end
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    int seed;
    logic [8:0] offer[2];
    seed = $urandom(59);
    foreach (img[a]) img[a] = 8'($urandom());
    bp = 7'($urandom()) | 7'h01;
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    check(32'(bus_address), 32'({bp[6:3], 3'h0}));
    info_wr_en = 1'b1;
    foreach (img[a]) begin
      info_wr_addr = 8'(a);
      info_wr_data = img[a];
      @(negedge sys_clk);
    end
    info_wr_en = 1'b0;
    check(32'(bus_address), 32'(bp));
    check(32'(alert), 32'h1);
    ack(1'b0);
    wait_cyc(2);
    check(32'(alert), 32'h0);
    std_status = 16'($urandom()) | 16'h0001;
    wait_cyc(3);
    check(32'(alert), 32'h1);
    ack(1'b1);
    wait_cyc(2);
    check(32'(alert), 32'h0);
    mfr_status = 16'h8000;
    wait_cyc(3);
    check(32'(alert), 32'h1);
    ack(1'b1);
    do_read(CMD_TARGETS, none, '{9'h100});
    host.unlock(PW_CHAR_3, 1'b0);
    wait_cyc(2);
    check(32'(unlocked), 32'h0);
    host.unlock(8'h45, 1'b1);
    wait_cyc(2);
    check(32'(unlocked), 32'h0);
    do_read(CMD_REVISION, '{CHAR_PRIMARY}, '{9'h100});
    host.unlock(PW_CHAR_3, 1'b1);
    wait_cyc(2);
    check(32'(unlocked), 32'h1);
    do_read(CMD_TARGETS, none, '{9'h003, {1'b0, CHAR_PRIMARY}, {1'b0, CHAR_SECONDARY},
      {1'b0, CHAR_INTERFACE}, 9'h0FF});
    for (int t = 0; t < 3; t++) begin
      info_read(CMD_COMPAT, t, 0, 16);
      info_read(CMD_REVISION, t, 1, 7);
      info_read(CMD_CAPABILITY, t, 2, 7);
    end
    do_read(CMD_COMPAT, '{8'h78}, '{9'h100});
    do_read(8'hE5, '{CHAR_PRIMARY}, '{9'h100});
    wait_cyc(4);
    check(32'(exp_q.size()), 32'h0);
    for (int i = 0; i < 4; i++) begin
      fan_a = (i == 2) ? 16'h004F : 16'h0064;
      fan_b = (i == 0) ? 16'h0050 : ((i == 1) ? 16'h004F : ((i == 2) ? 16'h0064 : 16'h0000));
      wait_cyc(3);
      check(32'({fan_warning, main_output_en}), 32'({i != 0, 1'b1}));
    end
    for (int i = 0; i < 9; i++) begin
      alarms = 9'h001 << i;
      wait_cyc(3);
      check(32'({info_warning, main_output_en}), 32'h3);
    end
    alarms = 9'h000;
    check(32'(output_good_lamp), 32'h1);
    remote_off = 1'b1;
    wait_cyc(3);
    check(32'(output_good_lamp), 32'h0);
    present = 1'b0;
    wait_cyc(4);
    present = 1'b1;
    wait_cyc(4);
    remote_off = 1'b0;
    wait_cyc(3);
    check(32'(output_good_lamp), 32'h1);
    lamp(0);
    offer[0] = 9'(img[8'h10]) + 9'h001;
    offer[1] = 9'(img[8'h50]);
    for (int t = 0; t < 2; t++) begin
      if (offer[t] > 9'(img[{t[1:0], 6'h10}])) begin
        boot(0);
        lamp(4);
        check(32'({app_run, main_output_en}), 32'h0);
        boot(1);
        lamp(8);
        boot(3);
        lamp(16);
        boot(4);
        check(32'(app_run), 32'h0);
        boot(1);
        boot(2);
        lamp(4);
        boot(4);
        lamp(0);
        check(32'({app_run, main_output_en}), 32'h3);
      end
    end
    wrap_up();
  end
endmodule // uci_top_tb
`default_nettype wire
